// ===== pdc_port_cfg.svh
// Purpose: Address map, field masks, reset values for the port direction block
// Assumes: Byte-wide processor memory bus, 16-bit addresses
// Notes:   Definitions only
`ifndef PDC_PORT_CFG_SVH
`define PDC_PORT_CFG_SVH

// ----------------------------------------
// Direction register addresses
// ----------------------------------------
`define PDC_ADDR_DIR0 16'hFF20
`define PDC_ADDR_DIR1 16'hFF21
`define PDC_ADDR_DIR3 16'hFF23
`define PDC_ADDR_DIR4 16'hFF24
`define PDC_ADDR_DIR6 16'hFF26
`define PDC_ADDR_DIR7 16'hFF27
`define PDC_ADDR_DIR8 16'hFF28
`define PDC_ADDR_DIR9 16'hFF29
`define PDC_ADDR_DIR12 16'hFF2C
`define PDC_ADDR_DIR13 16'hFF2D

// ----------------------------------------
// Writable bit masks of the direction registers
// ----------------------------------------
`define PDC_MASK_DIR0 8'h43
`define PDC_MASK_DIR1 8'hFF
`define PDC_MASK_DIR3 8'h0F
`define PDC_MASK_DIR4 8'h03
`define PDC_MASK_DIR6 8'h0F
`define PDC_MASK_DIR7 8'h0F
`define PDC_MASK_DIR8 8'hFF
`define PDC_MASK_DIR9 8'h01
`define PDC_MASK_DIR12 8'h1F
`define PDC_MASK_DIR13 8'h02

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDC_RST_DIR 8'hFF
`define PDC_RST_DIR13 8'hFE
`define PDC_RST_LATCH 8'h00
`define PDC_RST_PULLUP 8'h00

// ----------------------------------------
// Data latch and pull-up select addresses
// ----------------------------------------
`define PDC_ADDR_LAT9 16'hFF09
`define PDC_ADDR_LAT12 16'hFF0C
`define PDC_ADDR_LAT13 16'hFF0D
`define PDC_ADDR_FIVE_BIT_PORT_PULLUP_SEL 16'hFF3C
`define PDC_ADDR_TWO_BIT_PORT_PULLUP_SEL 16'hFF3D

// ----------------------------------------
// Implemented latch and pull-up bits
// ----------------------------------------
`define PDC_MASK_LAT9 8'h01
`define PDC_MASK_LAT12 8'h1F
`define PDC_MASK_LAT13 8'h03
`define PDC_MASK_FIVE_BIT_PORT_PULLUP_SEL 8'h01
`define PDC_MASK_TWO_BIT_PORT_PULLUP_SEL 8'h02

// ----------------------------------------
// Mode selections and counts
// ----------------------------------------
`define PDC_OSC_PORT_MODE 8'h00
`define PDC_ANALOG_PIN_CONFIG_ALL_ANALOG 8'h00
`define PDC_NUM_DIR 10
`define PDC_SYNC_STAGES 3

`endif

// ===== pdc_port_pkg.sv
// Purpose: Types shared by the port direction block
// Assumes: pdc_port_cfg.svh holds the numbers
// Notes:   Types only
`default_nettype none

package pdc_port_pkg;

   // ----------------------------------------
   // Processor bus request
   // ----------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic bit_wr;
      logic [2:0] bit_idx;
      logic [15:0] addr;
      logic [7:0] wdata;
   } pdc_bus_req_t;

   // ----------------------------------------
   // Drive of one two-way pin
   // ----------------------------------------
   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
   } pdc_pin_drv_t;

   typedef logic [7:0] pdc_byte_t;

endpackage

`default_nettype wire

// ===== pdc_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to i_clk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pdc_pin_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Pins
   input wire logic [W-1:0] i_pin,
   // Filtered level
   output logic [W-1:0] o_level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // ----------------------------------------
   // Agreement filter, one per bit
   // ----------------------------------------
   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               o_level[b] <= 1'b0;
            end else if (s2_q[b] == s3_q[b]) begin
               o_level[b] <= s3_q[b];
            end
         end
      end
   endgenerate

endmodule // pdc_pin_sync

`default_nettype wire

// ===== pdc_port_ctrl.sv
// Purpose: Port direction bank and pin control for the analog-shared,
//          five-bit and two-bit ports
// Assumes: Byte-wide processor memory bus on i_clk; analog config and
//          oscillator mode come from same-clock logic
// Notes:   Pin drives are registered, so they lag register writes by a cycle
`timescale 1ns/1ps
`default_nettype none
`include "pdc_port_cfg.svh"

module pdc_port_ctrl
   import pdc_port_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Processor bus
   input wire pdc_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // Mode selections from other blocks
   input wire logic [7:0] i_analog_pin_config,
   input wire logic [7:0] i_oscillator_mode_select,
   // Direction bank for other ports, index order 0,1,3,4,6,7,8,9,12,13
   output logic [`PDC_NUM_DIR*8-1:0] o_port_dirs,
   // Analog-shared pin
   input wire logic i_analog_shared_pin,
   output logic o_analog_shared_pin_out,
   output logic o_analog_shared_pin_oe,
   // Five-bit port pins
   input wire logic [4:0] i_five_bit_port_pin,
   output logic [4:0] o_five_bit_port_out,
   output logic [4:0] o_five_bit_port_oe,
   output logic o_five_bit_port_pin0_pu,
   // Two-bit port pins
   output logic o_output_only_pin,
   input wire logic i_two_bit_port_io_pin,
   output logic o_two_bit_port_io_pin_out,
   output logic o_two_bit_port_io_pin_oe,
   output logic o_two_bit_port_io_pin_pu
);

   // ----------------------------------------
   // Direction register table
   // ----------------------------------------
   localparam logic [15:0] DIR_ADDR [`PDC_NUM_DIR] = '{
      `PDC_ADDR_DIR0, `PDC_ADDR_DIR1, `PDC_ADDR_DIR3, `PDC_ADDR_DIR4,
      `PDC_ADDR_DIR6, `PDC_ADDR_DIR7, `PDC_ADDR_DIR8, `PDC_ADDR_DIR9,
      `PDC_ADDR_DIR12, `PDC_ADDR_DIR13};
   localparam logic [7:0] DIR_MASK [`PDC_NUM_DIR] = '{
      `PDC_MASK_DIR0, `PDC_MASK_DIR1, `PDC_MASK_DIR3, `PDC_MASK_DIR4,
      `PDC_MASK_DIR6, `PDC_MASK_DIR7, `PDC_MASK_DIR8, `PDC_MASK_DIR9,
      `PDC_MASK_DIR12, `PDC_MASK_DIR13};
   localparam logic [7:0] DIR_RST [`PDC_NUM_DIR] = '{
      `PDC_RST_DIR, `PDC_RST_DIR, `PDC_RST_DIR, `PDC_RST_DIR,
      `PDC_RST_DIR, `PDC_RST_DIR, `PDC_RST_DIR, `PDC_RST_DIR,
      `PDC_RST_DIR, `PDC_RST_DIR13};
   localparam int IDX9 = 7;
   localparam int IDX12 = 8;
   localparam int IDX13 = 9;

   pdc_byte_t dir_q [`PDC_NUM_DIR];
   pdc_byte_t lat9_q;
   pdc_byte_t lat12_q;
   pdc_byte_t lat13_q;
   pdc_byte_t five_bit_port_pullup_sel_q;
   pdc_byte_t two_bit_port_pullup_sel_q;
   pdc_byte_t rdata_d;
   logic [4:0] p12_lvl;
   logic two_bit_port_io_pin_lvl;
   logic p90_lvl;
   logic osc_port_mode;
   logic p90_digital;

   // ----------------------------------------
   // Byte or single-bit merge of a write
   // ----------------------------------------
   function automatic pdc_byte_t merge_wr(input pdc_byte_t old, input pdc_bus_req_t req,
                                          input pdc_byte_t mask, input pdc_byte_t fixed);
      pdc_byte_t nv;
      nv = old;
      if (req.bit_wr) begin
         nv[req.bit_idx] = req.wdata[0];
      end else begin
         nv = req.wdata;
      end
      merge_wr = (nv & mask) | (fixed & ~mask);
   endfunction

   // ----------------------------------------
   // Direction registers
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < `PDC_NUM_DIR; g++) begin : g_dir
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               dir_q[g] <= DIR_RST[g];
            end else if (i_bus.wr && i_bus.addr == DIR_ADDR[g]) begin
               // Fixed bits never move, so a stray write cannot free an absent pin
               dir_q[g] <= merge_wr(dir_q[g], i_bus, DIR_MASK[g], DIR_RST[g]);
            end
         end
         assign o_port_dirs[g*8 +: 8] = dir_q[g];
      end
   endgenerate

   // ----------------------------------------
   // Data latches and pull-up selects
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lat9_q <= `PDC_RST_LATCH;
         lat12_q <= `PDC_RST_LATCH;
         lat13_q <= `PDC_RST_LATCH;
      end else if (i_bus.wr) begin
         if (i_bus.addr == `PDC_ADDR_LAT9) begin
            lat9_q <= merge_wr(lat9_q, i_bus, `PDC_MASK_LAT9, 8'h00);
         end
         if (i_bus.addr == `PDC_ADDR_LAT12) begin
            lat12_q <= merge_wr(lat12_q, i_bus, `PDC_MASK_LAT12, 8'h00);
         end
         if (i_bus.addr == `PDC_ADDR_LAT13) begin
            lat13_q <= merge_wr(lat13_q, i_bus, `PDC_MASK_LAT13, 8'h00);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         five_bit_port_pullup_sel_q <= `PDC_RST_PULLUP;
         two_bit_port_pullup_sel_q <= `PDC_RST_PULLUP;
      end else if (i_bus.wr) begin
         if (i_bus.addr == `PDC_ADDR_FIVE_BIT_PORT_PULLUP_SEL) begin
            five_bit_port_pullup_sel_q <= merge_wr(five_bit_port_pullup_sel_q, i_bus, `PDC_MASK_FIVE_BIT_PORT_PULLUP_SEL, 8'h00);
         end
         if (i_bus.addr == `PDC_ADDR_TWO_BIT_PORT_PULLUP_SEL) begin
            two_bit_port_pullup_sel_q <= merge_wr(two_bit_port_pullup_sel_q, i_bus, `PDC_MASK_TWO_BIT_PORT_PULLUP_SEL, 8'h00);
         end
      end
   end

   // ----------------------------------------
   // Pin input synchronisers
   // ----------------------------------------
   pdc_pin_sync #(
      .W(7)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin({i_analog_shared_pin, i_two_bit_port_io_pin, i_five_bit_port_pin}),
      .o_level({p90_lvl, two_bit_port_io_pin_lvl, p12_lvl})
   );

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   assign osc_port_mode = (i_oscillator_mode_select == `PDC_OSC_PORT_MODE);
   assign p90_digital = (i_analog_pin_config != `PDC_ANALOG_PIN_CONFIG_ALL_ANALOG);

   // ----------------------------------------
   // Pin drive, registered
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_five_bit_port_out <= 5'h00;
         o_five_bit_port_oe <= 5'h00;
         o_five_bit_port_pin0_pu <= 1'b0;
      end else begin
         o_five_bit_port_out <= lat12_q[4:0];
         o_five_bit_port_oe[0] <= ~dir_q[IDX12][0];
         // Outside port mode the clock function owns the upper pins, their direction bits are ignored
         o_five_bit_port_oe[4:1] <= osc_port_mode ? ~dir_q[IDX12][4:1] : 4'h0;
         o_five_bit_port_pin0_pu <= five_bit_port_pullup_sel_q[0] & dir_q[IDX12][0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_output_only_pin <= 1'b0;
         o_two_bit_port_io_pin_out <= 1'b0;
         o_two_bit_port_io_pin_oe <= 1'b0;
         o_two_bit_port_io_pin_pu <= 1'b0;
      end else begin
         o_output_only_pin <= lat13_q[0];
         o_two_bit_port_io_pin_out <= lat13_q[1];
         o_two_bit_port_io_pin_oe <= ~dir_q[IDX13][1];
         o_two_bit_port_io_pin_pu <= two_bit_port_pullup_sel_q[1] & dir_q[IDX13][1];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_analog_shared_pin_out <= 1'b0;
         o_analog_shared_pin_oe <= 1'b0;
      end else begin
         o_analog_shared_pin_out <= lat9_q[0];
         // Driving an analog-selected pin would corrupt the conversion
         o_analog_shared_pin_oe <= p90_digital & ~dir_q[IDX9][0];
      end
   end

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   always_comb begin
      rdata_d = 8'h00;
      for (int i = 0; i < `PDC_NUM_DIR; i++) begin
         if (i_bus.addr == DIR_ADDR[i]) begin
            rdata_d = dir_q[i];
         end
      end
      unique case (i_bus.addr)
         `PDC_ADDR_LAT9: begin
            // Analog pin reads zero as a digital input
            rdata_d = {7'h00, dir_q[IDX9][0] ? (p90_lvl & p90_digital) : lat9_q[0]};
         end
         `PDC_ADDR_LAT12: begin
            rdata_d = {3'h0, (dir_q[IDX12][4:0] & p12_lvl)
                             | (~dir_q[IDX12][4:0] & lat12_q[4:0])};
         end
         `PDC_ADDR_LAT13: begin
            rdata_d = {6'h00, dir_q[IDX13][1] ? two_bit_port_io_pin_lvl : lat13_q[1], lat13_q[0]};
         end
         `PDC_ADDR_FIVE_BIT_PORT_PULLUP_SEL: begin
            rdata_d = five_bit_port_pullup_sel_q;
         end
         `PDC_ADDR_TWO_BIT_PORT_PULLUP_SEL: begin
            rdata_d = two_bit_port_pullup_sel_q;
         end
         default: begin
            rdata_d = rdata_d;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_bus.rd;
         if (i_bus.rd) begin
            o_rdata <= rdata_d;
         end
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_p13_byte_wr;
      i_bus.wr && !i_bus.bit_wr && i_bus.addr == `PDC_ADDR_LAT13;
   endsequence

   property p_output_only_pin_follow;
      @(posedge i_clk) disable iff (i_rst)
      s_p13_byte_wr ##2 1'b1 |-> o_output_only_pin == $past(i_bus.wdata[0], 2);
   endproperty
   a_output_only_pin_follow: assert property (p_output_only_pin_follow)
      else $error("output-only pin does not follow its latch");

   property p_dir_reset;
      @(posedge i_clk) disable iff (i_rst)
      $fell(i_rst) |-> dir_q[IDX13] == 8'hFE && dir_q[IDX12] == 8'hFF && dir_q[0] == 8'hFF;
   endproperty
   a_dir_reset: assert property (p_dir_reset)
      else $error("direction reset value wrong");

   property p_p12_out_mode;
      @(posedge i_clk) disable iff (i_rst)
      !dir_q[IDX12][0] |=> o_five_bit_port_oe[0];
   endproperty
   a_p12_out_mode: assert property (p_p12_out_mode)
      else $error("five-bit pin0 not driven in output mode");

   property p_pu_input_only;
      @(posedge i_clk) disable iff (i_rst)
      o_five_bit_port_pin0_pu |-> $past(dir_q[IDX12][0]) && $past(five_bit_port_pullup_sel_q[0]);
   endproperty
   a_pu_input_only: assert property (p_pu_input_only)
      else $error("pull-up on without input mode and select");

   property p_osc_owns_pins;
      @(posedge i_clk) disable iff (i_rst)
      !osc_port_mode |=> o_five_bit_port_oe[4:1] == 4'h0;
   endproperty
   a_osc_owns_pins: assert property (p_osc_owns_pins)
      else $error("upper pins driven under clock mode");

   property p_bit_write;
      @(posedge i_clk) disable iff (i_rst)
      i_bus.wr && i_bus.bit_wr && i_bus.addr == `PDC_ADDR_DIR12 && i_bus.bit_idx == 3'h0
      |=> dir_q[IDX12][0] == $past(i_bus.wdata[0])
          && dir_q[IDX12][4:1] == $past(dir_q[IDX12][4:1]);
   endproperty
   a_bit_write: assert property (p_bit_write)
      else $error("single-bit direction write wrong");

   property p_fixed_bits;
      @(posedge i_clk) disable iff (i_rst)
      dir_q[IDX12][7:5] == 3'h7 && dir_q[IDX13][0] == 1'b0 && dir_q[IDX9][7:1] == 7'h7F;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits)
      else $error("fixed direction bit changed");

   property p_pu_off_output;
      @(posedge i_clk) disable iff (i_rst)
      !dir_q[IDX13][1] |=> !o_two_bit_port_io_pin_pu && o_two_bit_port_io_pin_oe;
   endproperty
   a_pu_off_output: assert property (p_pu_off_output)
      else $error("pull-up on in output mode");

   property p_read_latch;
      @(posedge i_clk) disable iff (i_rst)
      i_bus.rd && i_bus.addr == `PDC_ADDR_LAT13 && !dir_q[IDX13][1]
      |=> o_rvalid && o_rdata[1] == $past(lat13_q[1]);
   endproperty
   a_read_latch: assert property (p_read_latch)
      else $error("output-mode read not from latch");

endmodule // pdc_port_ctrl

`default_nettype wire

// ===== pdc_port_ctrl_tb.sv
// Purpose: Self-checking bench for the port direction and pin control block
// Assumes: Bus driven on the falling edge, one access per request
// Notes:   Expected values come from a bench-side model of the registers
`timescale 1ns/1ps
`default_nettype none
`include "pdc_port_cfg.svh"

module pdc_port_ctrl_tb
   import pdc_port_pkg::*;
;
   // ----------------------------------------
   // Signals and model
   // ----------------------------------------
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   pdc_bus_req_t i_bus;
   logic [7:0] rdata, apc, osc;
   logic rvalid, ap_in, ap_out, ap_oe, fb_pu, oo, io_in, io_out, io_oe, io_pu;
   logic [4:0] fb_in, fb_out, fb_oe;
   logic [`PDC_NUM_DIR*8-1:0] dirs;
   logic [15:0] addr_t [10] = '{`PDC_ADDR_DIR0, `PDC_ADDR_DIR1, `PDC_ADDR_DIR3,
      `PDC_ADDR_DIR4, `PDC_ADDR_DIR6, `PDC_ADDR_DIR7, `PDC_ADDR_DIR8, `PDC_ADDR_DIR9,
      `PDC_ADDR_DIR12, `PDC_ADDR_DIR13};
   logic [7:0] mask_t [10] = '{`PDC_MASK_DIR0, `PDC_MASK_DIR1, `PDC_MASK_DIR3,
      `PDC_MASK_DIR4, `PDC_MASK_DIR6, `PDC_MASK_DIR7, `PDC_MASK_DIR8, `PDC_MASK_DIR9,
      `PDC_MASK_DIR12, `PDC_MASK_DIR13};
   logic [7:0] dir_m [10];
   logic [7:0] lat9_m, lat12_m, lat13_m, five_bit_port_pullup_sel_m, two_bit_port_pullup_sel_m, rd_v, exp_v;
   int fail_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #12.5 i_clk = ~i_clk;

   pdc_port_ctrl pdc_port_ctrl_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(rdata), .o_rvalid(rvalid),
      .i_analog_pin_config(apc), .i_oscillator_mode_select(osc), .o_port_dirs(dirs),
      .i_analog_shared_pin(ap_in), .o_analog_shared_pin_out(ap_out),
      .o_analog_shared_pin_oe(ap_oe), .i_five_bit_port_pin(fb_in),
      .o_five_bit_port_out(fb_out), .o_five_bit_port_oe(fb_oe),
      .o_five_bit_port_pin0_pu(fb_pu), .o_output_only_pin(oo),
      .i_two_bit_port_io_pin(io_in), .o_two_bit_port_io_pin_out(io_out),
      .o_two_bit_port_io_pin_oe(io_oe), .o_two_bit_port_io_pin_pu(io_pu)
   );

   // ----------------------------------------
   // Checks and closing
   // ----------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cut a hang short; the whole run needs a little over a thousand cycles
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("ERROR %0t timeout", $time);
         end_of_test();
      end
   end

   // ----------------------------------------
   // Model and bus tasks
   // ----------------------------------------
   function automatic logic [7:0] rst_val(input int k);
      return (k == 9) ? `PDC_RST_DIR13 : `PDC_RST_DIR;
   endfunction

   task automatic model_reset();
      for (int k = 0; k < 10; k++) dir_m[k] = rst_val(k);
      {lat9_m, lat12_m, lat13_m} = {3{`PDC_RST_LATCH}};
      {five_bit_port_pullup_sel_m, two_bit_port_pullup_sel_m} = {2{`PDC_RST_PULLUP}};
   endtask

   task automatic bus_wr(input logic [15:0] a, input logic b, input logic [2:0] i,
                         input logic [7:0] d);
      @(negedge i_clk);
      i_bus.wr = 1'b1;
      i_bus.bit_wr = b;
      i_bus.bit_idx = i;
      i_bus.addr = a;
      i_bus.wdata = d;
      @(negedge i_clk);
      i_bus.wr = 1'b0;
      i_bus.bit_wr = 1'b0;
   endtask

   task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge i_clk);
      i_bus.rd = 1'b1;
      i_bus.addr = a;
      @(negedge i_clk);
      i_bus.rd = 1'b0;
      d = rdata;
      chk_bit(rvalid, 1'b1, "read valid");
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      bus_wr(a, 1'b0, 3'h0, d);
      for (int k = 0; k < 10; k++) begin
         if (addr_t[k] == a) dir_m[k] = (d & mask_t[k]) | (rst_val(k) & ~mask_t[k]);
      end
      if (a == `PDC_ADDR_LAT9) lat9_m = d & `PDC_MASK_LAT9;
      if (a == `PDC_ADDR_LAT12) lat12_m = d & `PDC_MASK_LAT12;
      if (a == `PDC_ADDR_LAT13) lat13_m = d & `PDC_MASK_LAT13;
      if (a == `PDC_ADDR_FIVE_BIT_PORT_PULLUP_SEL) five_bit_port_pullup_sel_m = d & `PDC_MASK_FIVE_BIT_PORT_PULLUP_SEL;
      if (a == `PDC_ADDR_TWO_BIT_PORT_PULLUP_SEL) two_bit_port_pullup_sel_m = d & `PDC_MASK_TWO_BIT_PORT_PULLUP_SEL;
   endtask

   task automatic bit_dir(input int k, input logic [2:0] i, input logic v);
      logic [7:0] t;
      t = dir_m[k];
      t[i] = v;
      bus_wr(addr_t[k], 1'b1, i, {7'h00, v});
      dir_m[k] = (t & mask_t[k]) | (rst_val(k) & ~mask_t[k]);
   endtask

   task automatic check_dirs();
      for (int k = 0; k < 10; k++) begin
         bus_rd(addr_t[k], rd_v);
         chk_byte(rd_v, dir_m[k], "direction read");
         chk_byte(dirs[k*8 +: 8], dir_m[k], "direction bank");
      end
   endtask

   // Pin drives lag register and mode changes by one cycle
   task automatic chk_pins();
      logic [4:0] oe5;
      repeat (2) @(negedge i_clk);
      oe5 = ~dir_m[8][4:0] & ((osc == `PDC_OSC_PORT_MODE) ? 5'h1F : 5'h01);
      chk_byte({3'h0, fb_oe}, {3'h0, oe5}, "five-bit oe");
      chk_byte({3'h0, fb_out & oe5}, {3'h0, lat12_m[4:0] & oe5}, "five-bit out");
      chk_bit(fb_pu, five_bit_port_pullup_sel_m[0] & dir_m[8][0], "five-bit pull-up");
      chk_bit(oo, lat13_m[0], "output-only pin");
      chk_bit(io_oe, ~dir_m[9][1], "io pin oe");
      chk_bit(io_out & io_oe, lat13_m[1] & ~dir_m[9][1], "io pin out");
      chk_bit(io_pu, two_bit_port_pullup_sel_m[1] & dir_m[9][1], "io pin pull-up");
      chk_bit(ap_oe, (apc != `PDC_ANALOG_PIN_CONFIG_ALL_ANALOG) & ~dir_m[7][0], "analog oe");
      chk_bit(ap_out & ap_oe, lat9_m[0] & ap_oe, "analog out");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      i_bus = '0;
      apc = 8'h00;
      osc = 8'h00;
      {ap_in, io_in, fb_in} = 7'h00;
      void'($urandom(32'h0E3E));
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      model_reset();
      // Reset values and an unmapped place
      check_dirs();
      chk_pins();
      bus_rd(16'hFF2A, rd_v);
      chk_byte(rd_v, 8'h00, "unmapped read");
      wr_reg(16'hFF2A, 8'h00);
      wr_reg(`PDC_ADDR_DIR12, 8'h00);
      bus_rd(`PDC_ADDR_LAT12, rd_v);
      chk_byte(rd_v, `PDC_RST_LATCH, "latch after reset");
      check_dirs();
      $display("test reset done");
      // Byte writes: all clear, all set, then random
      for (int k = 0; k < 10; k++) wr_reg(addr_t[k], 8'h00);
      check_dirs();
      for (int k = 0; k < 10; k++) wr_reg(addr_t[k], 8'hFF);
      check_dirs();
      repeat (30) wr_reg(addr_t[$urandom_range(9, 0)], 8'($urandom));
      check_dirs();
      $display("test byte writes done");
      repeat (40) bit_dir($urandom_range(9, 0), 3'($urandom), 1'($urandom));
      // Corners: one-bit writes to pin 0 with one idle cycle between, alternate-function setups
      bit_dir(8, 3'h0, 1'b0);
      bit_dir(8, 3'h0, 1'b1);
      bit_dir(5, 3'h0, 1'b0);
      bit_dir(7, 3'h0, 1'b1);
      bit_dir(0, 3'h6, 1'b1);
      bit_dir(9, 3'h1, 1'b1);
      check_dirs();
      $display("test bit writes done");
      // Pin drives under random settings and modes
      repeat (25) begin
         wr_reg(`PDC_ADDR_DIR12, 8'($urandom));
         wr_reg(`PDC_ADDR_DIR13, 8'($urandom));
         wr_reg(`PDC_ADDR_DIR9, 8'($urandom));
         wr_reg(`PDC_ADDR_LAT12, 8'($urandom));
         wr_reg(`PDC_ADDR_LAT13, 8'($urandom));
         wr_reg(`PDC_ADDR_LAT9, 8'($urandom));
         wr_reg(`PDC_ADDR_FIVE_BIT_PORT_PULLUP_SEL, 8'($urandom));
         wr_reg(`PDC_ADDR_TWO_BIT_PORT_PULLUP_SEL, 8'($urandom));
         @(negedge i_clk);
         apc = $urandom_range(1, 0) ? 8'h00 : 8'($urandom_range(255, 1));
         osc = $urandom_range(1, 0) ? 8'h00 : 8'($urandom_range(255, 1));
         chk_pins();
      end
      $display("test pin drives done");
      // Data reads: pin level in input mode, latch in output mode
      osc = 8'h00;
      repeat (15) begin
         wr_reg(`PDC_ADDR_DIR12, 8'($urandom));
         wr_reg(`PDC_ADDR_DIR13, 8'($urandom));
         wr_reg(`PDC_ADDR_DIR9, 8'($urandom));
         @(negedge i_clk);
         {ap_in, io_in, fb_in} = 7'($urandom);
         apc = $urandom_range(1, 0) ? 8'h00 : 8'($urandom_range(255, 1));
         repeat (6) @(negedge i_clk);
         bus_rd(`PDC_ADDR_LAT12, rd_v);
         exp_v = {3'h0, (dir_m[8][4:0] & fb_in) | (~dir_m[8][4:0] & lat12_m[4:0])};
         chk_byte(rd_v, exp_v, "five-bit data read");
         bus_rd(`PDC_ADDR_LAT13, rd_v);
         exp_v = {6'h00, dir_m[9][1] ? io_in : lat13_m[1], lat13_m[0]};
         chk_byte(rd_v, exp_v, "two-bit data read");
         if (apc != `PDC_ANALOG_PIN_CONFIG_ALL_ANALOG || dir_m[7][0]) begin
            bus_rd(`PDC_ADDR_LAT9, rd_v);
            exp_v = {7'h00, (apc == `PDC_ANALOG_PIN_CONFIG_ALL_ANALOG) ? 1'b0 :
                     (dir_m[7][0] ? ap_in : lat9_m[0])};
            chk_byte(rd_v, exp_v, "analog data read");
         end
      end
      $display("test data reads done");
      // Output-only pin drops low at a reset in mid-run and stays low
      wr_reg(`PDC_ADDR_LAT13, 8'h01);
      chk_pins();
      @(negedge i_clk);
      i_rst = 1'b1;
      #1;
      chk_bit(oo, 1'b0, "output-only pin in reset");
      repeat (3) @(negedge i_clk);
      chk_bit(oo, 1'b0, "output-only pin held");
      chk_byte(dirs[9*8 +: 8], `PDC_RST_DIR13, "two-bit dir in reset");
      chk_byte({3'h0, fb_oe}, 8'h00, "five-bit oe in reset");
      i_rst = 1'b0;
      model_reset();
      check_dirs();
      chk_pins();
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule // pdc_port_ctrl_tb

`default_nettype wire
